// [tb_top.sv]
// Self-checking bench for the transmit parity checker and encoder.
// Assumes the host model file is compiled first.
`timescale 1ns/1ps
module tb_top;
   logic ref_clk_in, rst_in, psel, penable, pwrite, pready, pslverr, err;
   logic valid, ready, align_err, tick, ser, eflag;
   logic ready_low_seen = 1'b0;
   logic rd_seen = 1'b0;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] char_w;
   txpe_pkg::txpe_char_t char_bus;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   // Clock, low at time zero, 50 ns period
   initial begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   txpe_top i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .char_in(char_bus),
      .char_valid_in(valid), .char_ready_out(ready), .align_error_in(align_err),
      .char_out(char_w), .char_tick_out(tick), .serial_out(ser), .tx_error_flag_out(eflag));
   txpe_host_model i_host (.clk_in(ref_clk_in), .ready_in(ready), .char_out(char_bus),
      .valid_out(valid));
   // Hang guard and full-FIFO watch
   always @(posedge ref_clk_in) begin
      cycles++;
      if (!rst_in && ready === 1'b0) ready_low_seen <= 1'b1;
      if (cycles > 20000) begin
         bad_count++;
         wrap_up();
      end
   end
   // Receiver view of running disparity, from the weight of each emitted character
   always @(negedge ref_clk_in) begin
      if ($countones(char_w) > 5) begin
         rd_seen <= 1'b1;
      end else if ($countones(char_w) < 5) begin
         rd_seen <= 1'b0;
      end
   end
   task automatic wrap_up;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   function automatic txpe_pkg::txpe_char_t mk(input logic op, input logic sc,
      input logic [1:0] ct, input logic [7:0] d);
      return {op, sc, ct, d};
   endfunction
   // One APB transfer, waiting for pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_in);
      penable <= 1'b1;
      do @(posedge ref_clk_in); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_tick;
      do @(posedge ref_clk_in); while (tick !== 1'b1);
      #1;
   endtask
   // Send one character, check the emitted code, flag and serial order
   // e1 is the form sent at negative running disparity, e2 at positive
   task automatic xmit(input txpe_pkg::txpe_char_t c, input logic [9:0] e1,
      input logic [9:0] e2, input logic ef);
      logic [9:0] v;
      i_host.send(c);
      wait_tick();
      v = char_w;
      chk(v === (rd_seen ? e2 : e1), "emitted character");
      chk(eflag === ef, "error flag");
      for (int i = 0; i < 10; i++) begin
         chk(ser === v[i], "serial bit order");
         @(posedge ref_clk_in);
         #1;
      end
   endtask
   // Main sequence
   initial begin
      rst_in = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      align_err = 1'b0;
      repeat (6) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      // Registers: reset value, unmapped place, write back
      apb(1'b0, txpe_pkg::REG_CTRL, 32'h0);
      chk(rd === {25'h0, txpe_pkg::CTRL_RESET}, "control reset value");
      apb(1'b0, 8'h0C, 32'h0);
      chk(err === 1'b1 && rd === 32'h0, "unmapped read");
      apb(1'b1, txpe_pkg::REG_CTRL, 32'h0000_0010);
      apb(1'b0, txpe_pkg::REG_CTRL, 32'h0);
      chk(rd === 32'h0000_0010, "control write back");
      $display("test regs done");
      // Bypass mode, parity over all ten bits
      xmit(mk(1, 0, 2'b10, 8'hB5), 10'h2B5, 10'h2B5, 1'b0);
      xmit(mk(0, 0, 2'b10, 8'hB5), 10'h079, 10'h079, 1'b1);
      apb(1'b1, txpe_pkg::REG_CTRL, 32'h0000_0000);
      xmit(mk(0, 0, 2'b10, 8'hB5), 10'h2B5, 10'h2B5, 1'b0);
      $display("test bypass done");
      // Encoded mode 3, parity middle then high
      apb(1'b1, txpe_pkg::REG_CTRL, 32'h0000_0011);
      xmit(mk(0, 0, 2'b10, 8'hB5), 10'h155, 10'h155, 1'b0);
      apb(1'b1, txpe_pkg::REG_CTRL, 32'h0000_0021);
      xmit(mk(0, 0, 2'b10, 8'hB5), 10'h079, 10'h386, 1'b1);
      xmit(mk(0, 0, 2'b01, 8'h00), 10'h17C, 10'h283, 1'b0);
      xmit(mk(0, 1, 2'b01, 8'h05), 10'h17C, 10'h283, 1'b0);
      xmit(mk(1, 1, 2'b01, 8'hBC), 10'h17C, 10'h283, 1'b0);
      xmit(mk(1, 1, 2'b01, 8'h20), 10'h079, 10'h386, 1'b0);
      wait_tick();
      chk(char_w === (rd_seen ? 10'h283 : 10'h17C), "fill character");
      xmit(mk(1, 0, 2'b11, 8'h00), 10'h17C, 10'h283, 1'b0);
      // Members 2 and 3 take the reversed disparity, the rest follow the rules
      for (int i = 1; i < 16; i++) begin
         chk(char_w === ((rd_seen ^ (i < 3)) ? 10'h283 : 10'h17C), "sync member");
         wait_tick();
      end
      // Error count and sticky flag, then their clears
      apb(1'b0, txpe_pkg::REG_ERRCNT, 32'h0);
      chk(rd === 32'h0000_0002, "parity error count");
      apb(1'b0, txpe_pkg::REG_STATUS, 32'h0);
      chk(rd[txpe_pkg::STAT_PERR_POS] === 1'b1, "sticky parity error");
      apb(1'b1, txpe_pkg::REG_STATUS, 32'h0000_0002);
      apb(1'b1, txpe_pkg::REG_ERRCNT, 32'h0);
      apb(1'b0, txpe_pkg::REG_STATUS, 32'h0);
      chk(rd[txpe_pkg::STAT_PERR_POS] === 1'b0, "sticky parity clear");
      apb(1'b0, txpe_pkg::REG_ERRCNT, 32'h0);
      chk(rd === 32'h0, "parity count clear");
      $display("test encode done");
      // Self-test replaces host characters, then mode 7 sync by special select
      apb(1'b1, txpe_pkg::REG_CTRL, 32'h0000_0061);
      wait_tick();
      chk(char_w === (rd_seen ? 10'h1CA : 10'h235), "first self-test character");
      i_host.send(mk(0, 0, 2'b10, 8'hB5));
      wait_tick();
      chk(eflag === 1'b0 && char_w !== 10'h079 && char_w !== 10'h386, "self-test input");
      apb(1'b1, txpe_pkg::REG_CTRL, 32'h0000_0026);
      xmit(mk(0, 1, 2'b01, 8'h00), 10'h17C, 10'h283, 1'b0);
      xmit(mk(1, 0, 2'b10, 8'hB5), 10'h155, 10'h155, 1'b0);
      apb(1'b1, txpe_pkg::REG_CTRL, 32'h0000_0021);
      $display("test selftest done");
      // Align buffer error replaces characters
      @(posedge ref_clk_in);
      align_err <= 1'b1;
      wait_tick();
      wait_tick();
      chk(char_w === (rd_seen ? 10'h386 : 10'h079), "align error character");
      chk(eflag === 1'b1, "align error flag");
      @(posedge ref_clk_in);
      align_err <= 1'b0;
      wait_tick();
      wait_tick();
      $display("test align done");
      // Fill the FIFO until it refuses, then let it drain
      for (int i = 0; i < 12; i++) begin
         i_host.send(mk(0, 0, 2'b00, 8'hB5));
      end
      chk(ready_low_seen === 1'b1, "FIFO never refused");
      repeat (120) @(posedge ref_clk_in);
      apb(1'b0, txpe_pkg::REG_STATUS, 32'h0);
      chk(rd[7:4] === 4'h0, "FIFO not drained");
      $display("test fifo done");
      wrap_up();
   end
endmodule

// [txpe_enc.sv]
// Combinational 8B/10B encoder for data and special characters.
// Assumes the caller keeps running disparity; output bit 0 is sent first.
`timescale 1ns/1ps
module txpe_enc (
   // Character in
   input wire logic [7:0] byte_in,
   input wire logic k_in,
   input wire logic rd_in,
   // Code out
   output logic [9:0] code_out
);
   logic [4:0] x;
   logic [2:0] y;
   logic [5:0] s6;
   logic [5:0] c6;
   logic [3:0] s4;
   logic [3:0] c4;
   logic rdm;
   logic alt;
   logic k28;
   logic flip4;
   // 6B part, then 4B part with the disparity left after the 6B part
   always_comb begin
      x = byte_in[4:0];
      y = byte_in[7:5];
      k28 = k_in && (x == 5'd28);
      s6 = k28 ? txpe_pkg::K28_6B : txpe_pkg::T6[x];
      c6 = (rd_in && ($countones(s6) != 3 || x == 5'd7)) ? ~s6 : s6;
      rdm = ($countones(s6) != 3) ? ~rd_in : rd_in;
      alt = (y == 3'd7) && (k_in
            || (!rdm && (x == 5'd17 || x == 5'd18 || x == 5'd20))
            || (rdm && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
      s4 = alt ? txpe_pkg::A7_4B : txpe_pkg::T4[y];
      flip4 = ($countones(s4) != 2 || y == 3'd3) ? rdm : (k28 && !rdm);
      c4 = flip4 ? ~s4 : s4;
   end
   // Reverse abcdeifghj so that a leaves first
   assign code_out = {<<{c6, c4}};
endmodule

// [txpe_fifo.sv]
// Character FIFO between host and encoder, flip-flop storage.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ps
module txpe_fifo #(
   parameter int W = 12,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Fill side
   input wire logic [W-1:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   // Drain side
   output logic [W-1:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   // Fill level
   output logic [$clog2(DEPTH):0] level_out
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;
   // Handshakes and honest full and empty
   assign wr_ready_out = cnt_q != (AW+1)'(DEPTH);
   assign rd_valid_out = cnt_q != '0;
   assign push = wr_valid_in && wr_ready_out;
   assign pop = rd_valid_out && rd_ready_in;
   assign rd_data_out = mem_q[rp_q];
   assign level_out = cnt_q;
   // Storage, written by index
   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem_q[wp_q] <= wr_data_in;
      end
   end
   // Pointers and count
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
         if (push && !pop) cnt_q <= cnt_q + 1'b1;
         else if (pop && !push) cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule

// [txpe_host_model.sv]
// Host-side character source feeding the transmit encoder.
// Assumes the block takes a character at any edge with valid and ready high.
`timescale 1ns/1ps
module txpe_host_model (
   // Clock
   input wire logic clk_in,
   // Character handshake
   input wire logic ready_in,
   output txpe_pkg::txpe_char_t char_out,
   output logic valid_out
);
   // Idle at time zero
   initial begin
      char_out = '0;
      valid_out = 1'b0;
   end
   // Present one whole character and hold it until it is taken
   task automatic send(input txpe_pkg::txpe_char_t c);
      @(posedge clk_in);
      char_out <= c;
      valid_out <= 1'b1;
      do @(posedge clk_in); while (ready_in !== 1'b1);
      valid_out <= 1'b0;
      // Released lines must not keep showing the old character
      char_out <= ~c;
   endtask
endmodule

// [txpe_pkg.sv]
// Shared types, register map, field layout and code tables of the transmit
// parity checker and 8B/10B encoder.
// Assumes a 32-bit APB slave and one 20 MHz clock.
package txpe_pkg;
   // Three-level select held in a two-bit field
   typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} txpe_lvl_t;
   // One host character as captured by the input register
   typedef struct packed {
      logic odd_parity;
      logic special_code_select;
      logic [1:0] tx_control_bits;
      logic [7:0] data;
   } txpe_char_t;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_ERRCNT = 8'h08;
   // Control fields and reset value: mode MID/LOW (mode 3), parity MID
   localparam int CTRL_W = 7;
   localparam int CTRL_MODE_HI_POS = 0;
   localparam int CTRL_MODE_LO_POS = 2;
   localparam int CTRL_PAR_POS = 4;
   localparam int CTRL_BIST_POS = 6;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h11;
   // Status fields
   localparam int STAT_RD_POS = 0;
   localparam int STAT_PERR_POS = 1;
   localparam int STAT_ALIGN_POS = 2;
   localparam int STAT_WS_POS = 3;
   localparam int STAT_LVL_POS = 4;
   // Timing: one serial bit per clock, ten bits per character
   localparam int CHAR_CYCLES = 10;
   // Characters, in transmission order (bit 0 goes out first)
   localparam logic [9:0] C07_POS = 10'h079;
   localparam logic [9:0] C07_NEG = 10'h386;
   localparam logic [7:0] K285_BYTE = 8'hBC;
   localparam logic [3:0] WS_LAST = 4'hF;
   localparam logic [8:0] LFSR_SEED = 9'h1FF;
   // 5B/6B codes, abcdei with a in bit 5, negative running disparity form
   localparam logic [5:0] T6 [32] = '{
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [5:0] K28_6B = 6'h0F;
   // 3B/4B codes, fghj with f in bit 3, and the alternate x.7 code
   localparam logic [3:0] T4 [8] = '{
      4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
   localparam logic [3:0] A7_4B = 4'h7;
   // Indexed special-code map (second map is the direct K byte value)
   localparam int SPEC_N = 12;
   localparam logic [7:0] SPEC_MAP [SPEC_N] = '{
      8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC,
      8'hDC, 8'hFC, 8'hF7, 8'hFB, 8'hFD, 8'hFE};
   // Decode a three-level field, the spare code reads as HIGH
   function automatic txpe_lvl_t txpe_lvl(input logic [1:0] f);
      txpe_lvl_t l;
      l = (f == 2'h0) ? LVL_LOW : (f == 2'h1) ? LVL_MID : LVL_HIGH;
      return l;
   endfunction
endpackage

// [txpe_top.sv]
// Transmit parity checker and 8B/10B character encoder with APB registers.
// Assumes host characters synchronous to ref_clk_in and one bit per clock out.
//
// How it works
// - Odd parity check offered in every mode
// - Parity MID encoded: data plus parity bit
// - HIGH, or MID bypassed: data, control, parity
// - Parity LOW: no check, no substitution
// - Encoded parity error sends disparity-correct C0.7
// - Bypassed parity error sends positive C0.7
// - Parity bit captured with character, select governs
// - Encoder enabled: data or special coding
// - Bypass passes ten captured bits unchanged
// - Align buffer error sends C0.7 continuously
// - Self-test sends 511-character sequence
// - K28.5 alone or in 16-character sync
// - Character chosen per period from selects
// - Two non-overlapping special code maps
// - Ten-bit character shifted out LSB first
// - Positive C0.7 is fixed 1001111000 pattern
// - Parity errors raise transmit error flag
// - Modes 3/6 control bits choose character
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module txpe_top #(
   parameter int ADDR_W = 8,
   parameter int FIFO_DEPTH = 8,
   parameter int CHAR_CYCLES = txpe_pkg::CHAR_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Host characters
   input wire txpe_pkg::txpe_char_t char_in,
   input wire logic char_valid_in,
   output logic char_ready_out,
   // Phase-align buffer error level
   input wire logic align_error_in,
   // Transmit side
   output logic [9:0] char_out,
   output logic char_tick_out,
   output logic serial_out,
   output logic tx_error_flag_out
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;
   localparam int DW = $clog2(CHAR_CYCLES);
   // Registers
   logic [txpe_pkg::CTRL_W-1:0] ctrl_q;
   logic perr_sticky_q;
   logic [15:0] errcnt_q;
   logic [31:0] prdata_q;
   // Character path state
   logic [DW-1:0] div_q;
   logic [9:0] char_q;
   logic [9:0] sh_q;
   logic rd_q;
   logic [3:0] ws_q;
   logic [8:0] lfsr_q;
   logic tx_err_q;
   // Combinational
   logic tick;
   txpe_pkg::txpe_char_t c;
   logic have;
   logic [LW-1:0] level;
   txpe_pkg::txpe_lvl_t mode_hi;
   txpe_pkg::txpe_lvl_t mode_lo;
   txpe_pkg::txpe_lvl_t par_sel;
   logic bist_en;
   logic enc_en;
   logic atomic;
   logic ws_busy;
   logic [3:0] ws_next;
   logic par_chk;
   logic par_ok;
   logic par_err;
   logic spec_ok;
   logic [7:0] spec_byte;
   logic [7:0] enc_byte;
   logic enc_k;
   logic enc_rd;
   logic [9:0] enc_code;
   logic viol;
   logic raw_sel;
   logic [3:0] ws_d;
   logic [9:0] sel_char;
   logic [31:0] rdata;
   logic mapped;
   logic wr_acc;

   // Control field decode
   assign mode_hi = txpe_pkg::txpe_lvl(ctrl_q[txpe_pkg::CTRL_MODE_HI_POS +: 2]);
   assign mode_lo = txpe_pkg::txpe_lvl(ctrl_q[txpe_pkg::CTRL_MODE_LO_POS +: 2]);
   assign par_sel = txpe_pkg::txpe_lvl(ctrl_q[txpe_pkg::CTRL_PAR_POS +: 2]);
   assign bist_en = ctrl_q[txpe_pkg::CTRL_BIST_POS];
   assign enc_en = mode_hi != txpe_pkg::LVL_LOW;
   assign atomic = mode_hi == txpe_pkg::LVL_MID;

   // Character clock enable from the divider
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         div_q <= '0;
      end else if (tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   assign tick = div_q == DW'(CHAR_CYCLES - 1);

   // Input register: character FIFO drained once per character period
   txpe_fifo #(
      .W($bits(txpe_pkg::txpe_char_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .wr_data_in(char_in),
      .wr_valid_in(char_valid_in),
      .wr_ready_out(char_ready_out),
      .rd_data_out(c),
      .rd_valid_out(have),
      .rd_ready_in(tick),
      .level_out(level)
   );

   // Parity coverage chosen by the three-level select
   always_comb begin
      par_chk = 1'b0;
      par_ok = 1'b1;
      if (par_sel == txpe_pkg::LVL_HIGH || (par_sel == txpe_pkg::LVL_MID && !enc_en)) begin
         par_chk = 1'b1;
         par_ok = ^{c.data, c.tx_control_bits, c.odd_parity};
      end else if (par_sel == txpe_pkg::LVL_MID) begin
         par_chk = 1'b1;
         par_ok = ^{c.data, c.odd_parity};
      end
   end
   assign ws_busy = ws_q != 4'h0;
   assign ws_next = (ws_q == txpe_pkg::WS_LAST) ? 4'h0 : ws_q + 4'h1;
   // Atomic sync ignores the input after its first character
   assign par_err = have && par_chk && !par_ok && !bist_en
                    && !(enc_en && atomic && ws_busy);

   // Special codes: indexed map or direct K byte, never overlapping
   always_comb begin
      spec_ok = 1'b0;
      spec_byte = txpe_pkg::K285_BYTE;
      if (c.data[4:0] == 5'd28 || c.data == 8'hF7 || c.data == 8'hFB
          || c.data == 8'hFD || c.data == 8'hFE) begin
         spec_ok = 1'b1;
         spec_byte = c.data;
      end else if (c.data < 8'(txpe_pkg::SPEC_N)) begin
         spec_ok = 1'b1;
         spec_byte = txpe_pkg::SPEC_MAP[c.data[3:0]];
      end
   end

   // Character selection for this period, highest priority first
   always_comb begin
      enc_byte = txpe_pkg::K285_BYTE;
      enc_k = 1'b1;
      enc_rd = rd_q;
      viol = 1'b0;
      raw_sel = 1'b0;
      ws_d = 4'h0;
      if (align_error_in) begin
         viol = 1'b1;
      end else if (bist_en) begin
         enc_byte = lfsr_q[7:0];
         enc_k = 1'b0;
      end else if (enc_en && atomic && ws_busy) begin
         ws_d = ws_next;
      end else if (!have) begin
         enc_k = 1'b1;
      end else if (par_err) begin
         viol = 1'b1;
      end else if (!enc_en) begin
         raw_sel = 1'b1;
      end else if (ws_busy && c.tx_control_bits == 2'b00) begin
         ws_d = ws_next;
      end else if (!c.tx_control_bits[0]) begin
         enc_byte = c.data;
         enc_k = 1'b0;
      end else if (c.tx_control_bits[1]
                   || (mode_lo == txpe_pkg::LVL_MID && c.special_code_select)) begin
         ws_d = 4'h1;
      end else if (mode_lo == txpe_pkg::LVL_LOW && !c.special_code_select) begin
         enc_k = 1'b1;
      end else if (spec_ok) begin
         enc_byte = spec_byte;
      end else begin
         viol = 1'b1;
      end
      // Second and third sync characters take the reversed disparity
      if (ws_d == 4'h2 || ws_d == 4'h3) begin
         enc_rd = !rd_q;
      end
   end

   txpe_enc u_enc (
      .byte_in(enc_byte),
      .k_in(enc_k),
      .rd_in(enc_rd),
      .code_out(enc_code)
   );

   // Final character: violation, raw, or encoded
   always_comb begin
      if (viol && enc_en) begin
         sel_char = rd_q ? txpe_pkg::C07_NEG : txpe_pkg::C07_POS;
      end else if (viol) begin
         sel_char = txpe_pkg::C07_POS;
      end else if (raw_sel) begin
         sel_char = {c.tx_control_bits, c.data};
      end else begin
         sel_char = enc_code;
      end
   end

   // Character period state
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         char_q <= txpe_pkg::C07_POS;
         rd_q <= 1'b0;
         ws_q <= 4'h0;
         tx_err_q <= 1'b0;
      end else if (tick) begin
         char_q <= sel_char;
         ws_q <= ws_d;
         tx_err_q <= par_err || align_error_in;
         if ($countones(sel_char) > 5) rd_q <= 1'b1;
         else if ($countones(sel_char) < 5) rd_q <= 1'b0;
      end
   end

   // Self-test sequence generator, period 511
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         lfsr_q <= txpe_pkg::LFSR_SEED;
      end else if (tick && bist_en && !align_error_in) begin
         lfsr_q <= {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
      end
   end

   // Transmit shifter, bit 0 first
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sh_q <= txpe_pkg::C07_POS;
      end else if (tick) begin
         sh_q <= sel_char;
      end else begin
         sh_q <= {1'b0, sh_q[9:1]};
      end
   end
   assign serial_out = sh_q[0];
   assign char_out = char_q;
   assign char_tick_out = tick;
   assign tx_error_flag_out = tx_err_q;

   // APB decode, zero wait states
   assign mapped = paddr_in == txpe_pkg::REG_CTRL || paddr_in == txpe_pkg::REG_STATUS
                   || paddr_in == txpe_pkg::REG_ERRCNT;
   assign wr_acc = psel_in && penable_in && pwrite_in && mapped;
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped;
   assign prdata_out = prdata_q;

   // Read mux
   always_comb begin
      rdata = 32'h0000_0000;
      case (paddr_in)
         txpe_pkg::REG_CTRL: begin
            rdata[txpe_pkg::CTRL_W-1:0] = ctrl_q;
         end
         txpe_pkg::REG_STATUS: begin
            rdata[txpe_pkg::STAT_RD_POS] = rd_q;
            rdata[txpe_pkg::STAT_PERR_POS] = perr_sticky_q;
            rdata[txpe_pkg::STAT_ALIGN_POS] = align_error_in;
            rdata[txpe_pkg::STAT_WS_POS] = ws_busy;
            rdata[txpe_pkg::STAT_LVL_POS +: LW] = level;
         end
         txpe_pkg::REG_ERRCNT: begin
            rdata[15:0] = errcnt_q;
         end
         default: begin
            rdata = 32'h0000_0000;
         end
      endcase
   end

   // Read data captured in the setup phase
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel_in && !penable_in) begin
         prdata_q <= rdata;
      end
   end

   // Control register
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q <= txpe_pkg::CTRL_RESET;
      end else if (wr_acc && paddr_in == txpe_pkg::REG_CTRL) begin
         ctrl_q <= pwdata_in[txpe_pkg::CTRL_W-1:0];
      end
   end

   // Sticky parity error, write one to clear, a new error wins
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         perr_sticky_q <= 1'b0;
      end else if (tick && par_err) begin
         perr_sticky_q <= 1'b1;
      end else if (wr_acc && paddr_in == txpe_pkg::REG_STATUS
                   && pwdata_in[txpe_pkg::STAT_PERR_POS]) begin
         perr_sticky_q <= 1'b0;
      end
   end

   // Saturating parity error count, any write clears, a new error wins
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         errcnt_q <= 16'h0000;
      end else if (tick && par_err) begin
         if (errcnt_q != 16'hFFFF) errcnt_q <= errcnt_q + 16'h0001;
      end else if (wr_acc && paddr_in == txpe_pkg::REG_ERRCNT) begin
         errcnt_q <= 16'h0000;
      end
   end

   // Checks on the character path
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   AST_NO_PARITY_LOW: assert property (
      par_sel == txpe_pkg::LVL_LOW |-> !par_err)
      else $error("parity error raised with checking off");
   AST_MID_ENC_CTL_IGNORED: assert property (
      (par_sel == txpe_pkg::LVL_MID && enc_en && have && !bist_en && !ws_busy
       && ^{c.data, c.odd_parity}) |-> !par_err)
      else $error("control bits affected mid-level parity");
   AST_HIGH_CTL_CHECKED: assert property (
      (par_sel == txpe_pkg::LVL_HIGH && have && !bist_en && !ws_busy
       && !(^{c.data, c.tx_control_bits, c.odd_parity})) |-> par_err)
      else $error("bad parity over control bits missed");
   AST_ENC_VIOL: assert property (
      (tick && enc_en && par_err && !align_error_in)
      |=> char_q == ($past(rd_q) ? txpe_pkg::C07_NEG : txpe_pkg::C07_POS))
      else $error("wrong violation character when encoding");
   AST_BYPASS_VIOL: assert property (
      (tick && !enc_en && (par_err || align_error_in)) |=> char_q == 10'h079)
      else $error("bypass violation not the fixed pattern");
   AST_BYPASS_PASS: assert property (
      (tick && !enc_en && have && !par_err && !align_error_in && !bist_en)
      |=> char_q == $past({c.tx_control_bits, c.data}))
      else $error("bypass character altered");
   AST_ALIGN_VIOL: assert property (
      (tick && align_error_in)
      |=> (char_q == txpe_pkg::C07_POS || char_q == txpe_pkg::C07_NEG) && tx_error_flag_out)
      else $error("align error did not force violation");
   AST_LSB_FIRST: assert property (
      tick |=> serial_out == char_q[0] ##1 serial_out == char_q[1]
               ##1 serial_out == char_q[2])
      else $error("shifter not sending bit 0 first");
   AST_ATOMIC_SYNC: assert property (
      (tick && ws_q == 4'h1 && atomic && enc_en && !align_error_in && !bist_en)
      |=> ws_q == 4'h2)
      else $error("atomic sync sequence interrupted");
   AST_RD_TRACK: assert property (
      (tick ##1 $countones(char_q) == 6) |-> rd_q)
      else $error("running disparity not updated");
   AST_ERR_FLAG: assert property (
      (tick && par_err) |=> tx_error_flag_out && perr_sticky_q)
      else $error("parity error not flagged");

   COV_PARITY_VIOL: cover property (tick && par_err && enc_en);
   COV_BYPASS_VIOL: cover property (tick && par_err && !enc_en);
   COV_SYNC_END: cover property (tick && ws_q == txpe_pkg::WS_LAST);
   COV_FIFO_FULL: cover property (!char_ready_out && char_valid_in);
endmodule
